/* shared/frt_pkg.sv */
package frt_pkg;
	// Register word byte addresses (each byte register on one aligned word)
	localparam logic [5:0] ADR_COUNT_HIGH = 6'h00;
	localparam logic [5:0] ADR_COUNT_LOW = 6'h04;
	localparam logic [5:0] ADR_SHADOW_HIGH = 6'h08;
	localparam logic [5:0] ADR_SHADOW_LOW = 6'h0c;
	localparam logic [5:0] ADR_CAP1_HIGH = 6'h10;
	localparam logic [5:0] ADR_CAP1_LOW = 6'h14;
	localparam logic [5:0] ADR_CAP2_HIGH = 6'h18;
	localparam logic [5:0] ADR_CAP2_LOW = 6'h1c;
	localparam logic [5:0] ADR_FLAGS = 6'h20;
	localparam logic [5:0] ADR_CTRL_ONE = 6'h24;
	localparam logic [5:0] ADR_CTRL_TWO = 6'h28;
	// control_register_one fields
	localparam int CR1_CAP_IRQ_EN = 7;
	localparam int CR1_WRAP_IRQ_EN = 5;
	localparam int CR1_CAP1_EDGE = 1;
	// control_register_two fields
	localparam int CR2_ONE_PULSE = 4;
	localparam int CR2_PWM = 5;
	localparam int CR2_CLK_SEL_LO = 2;
	localparam int CR2_CAP2_EDGE = 1;
	localparam int CR2_EXT_EDGE = 0;
	// timer_flags_register fields
	localparam int SR_CAP1_FLAG = 7;
	localparam int SR_CAP2_FLAG = 4;
	localparam int SR_WRAP_FLAG = 5;
	// Clock select encodings
	localparam logic [1:0] CLK_DIV2 = 2'h0;
	localparam logic [1:0] CLK_DIV4 = 2'h1;
	localparam logic [1:0] CLK_DIV8 = 2'h2;
	localparam logic [1:0] CLK_EXT = 2'h3;
	// Reset and reload values
	localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
	localparam logic [15:0] COUNT_TOP = 16'hffff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] CAP_RESET = 16'h0000;
	localparam logic [2:0] PRESC_RESET = 3'h0;
endpackage

/* rtl/free_running_timer_capture.sv */
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - Counter clock is CPU clock over 2, 4, 8 or external input.
// - Counter and shadow view reset to FFFCh; only value ever reloaded.
// - Writing count low or shadow low byte forces counter to FFFCh.
// - High byte read first buffers low byte until low byte read.
// - After a completed sequence a lone low read returns live low byte.
// - Shadow registers mirror count but never clear the wrap flag.
// - Wrap flag sets when counter rolls from FFFFh to 0000h.
// - Wrap interrupt when flag, enable set and CPU mask clear; else pending.
// - Wrap flag clears after flags read while set, then count low access.
// - Counter runs in wait; halts in halt, resumes held count.
// - External clocking chosen when both clock select bits are one.
// - Edge select bit picks rising or falling external count edges.
// - External edges are synchronised; source must be below quarter rate.
// - Each capture channel latches the counter on its pin's active edge.
// - Channel one edge bit in control one, channel two in control two.
// - One capture interrupt enable governs both capture channels.
// - Capture sets channel flag; interrupt when enabled and unmasked.
// - Capture flag clears after flags read while set, then low access.
// - Capture high read blocks that channel until its low byte read.
// - In one pulse or PWM mode only capture channel two operates.
// - Capture pins always feed capture logic, even when driven as outputs.
// - Capture flag appears two to three CPU clocks after pin event.
module free_running_timer_capture (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [5:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_cpu_irq_mask,
	input wire logic i_halt,
	input wire logic i_ext_count_input,
	input wire logic i_capture_pin_one,
	input wire logic i_capture_pin_two,
	output logic o_irq
);

	// Edge test shared by external clock and both capture pins
	function automatic logic edge_hit(input logic now, input logic was, input logic rising);
		edge_hit = rising ? (now & ~was) : (~now & was);
	endfunction

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [2:0] presc_reg;
	logic [7:0] ctrl_one_reg;
	logic [7:0] ctrl_two_reg;
	logic [7:0] low_buf_reg;
	logic buf_armed_reg;
	logic wrap_flag_reg;
	logic wrap_clr_arm_reg;
	logic [15:0] cap1_reg;
	logic [15:0] cap2_reg;
	logic cap1_flag_reg;
	logic cap2_flag_reg;
	logic cap1_clr_arm_reg;
	logic cap2_clr_arm_reg;
	logic cap1_block_reg;
	logic cap2_block_reg;
	logic [2:0] ext_sync_reg;
	logic [2:0] pin1_sync_reg;
	logic [2:0] pin2_sync_reg;
	logic [31:0] rd_data_reg;
	logic ack_reg;
	logic irq_reg;

	// Bus request decode; a request is taken once, answered next edge
	wire take = i_wb_cyc & i_wb_stb & ~ack_reg;
	wire rd = take & ~i_wb_we;
	wire wr = take & i_wb_we & i_wb_sel[0];
	wire hit_cnt_hi = i_wb_adr == frt_pkg::ADR_COUNT_HIGH;
	wire hit_cnt_lo = i_wb_adr == frt_pkg::ADR_COUNT_LOW;
	wire hit_sh_hi = i_wb_adr == frt_pkg::ADR_SHADOW_HIGH;
	wire hit_sh_lo = i_wb_adr == frt_pkg::ADR_SHADOW_LOW;
	wire hit_c1_hi = i_wb_adr == frt_pkg::ADR_CAP1_HIGH;
	wire hit_c1_lo = i_wb_adr == frt_pkg::ADR_CAP1_LOW;
	wire hit_c2_hi = i_wb_adr == frt_pkg::ADR_CAP2_HIGH;
	wire hit_c2_lo = i_wb_adr == frt_pkg::ADR_CAP2_LOW;
	wire hit_flags = i_wb_adr == frt_pkg::ADR_FLAGS;
	wire hit_cr1 = i_wb_adr == frt_pkg::ADR_CTRL_ONE;
	wire hit_cr2 = i_wb_adr == frt_pkg::ADR_CTRL_TWO;

	// Byte-register events seen by the timer logic
	wire rd_high = rd & (hit_cnt_hi | hit_sh_hi);
	wire rd_low = rd & (hit_cnt_lo | hit_sh_lo);
	wire wr_low = wr & (hit_cnt_lo | hit_sh_lo);
	wire cnt_lo_access = take & hit_cnt_lo;
	wire flags_read = rd & hit_flags;
	wire c1_lo_access = take & hit_c1_lo;
	wire c2_lo_access = take & hit_c2_lo;

	// Control fields
	wire [1:0] clk_sel = ctrl_two_reg[frt_pkg::CR2_CLK_SEL_LO +: 2];
	wire wrap_irq_enable = ctrl_one_reg[frt_pkg::CR1_WRAP_IRQ_EN];
	wire capture_irq_enable = ctrl_one_reg[frt_pkg::CR1_CAP_IRQ_EN];
	wire cap1_rising = ctrl_one_reg[frt_pkg::CR1_CAP1_EDGE];
	wire cap2_rising = ctrl_two_reg[frt_pkg::CR2_CAP2_EDGE];
	wire ext_rising = ctrl_two_reg[frt_pkg::CR2_EXT_EDGE];
	wire wave_mode = ctrl_two_reg[frt_pkg::CR2_ONE_PULSE] | ctrl_two_reg[frt_pkg::CR2_PWM];

	// Prescaled tick: all low prescaler bits at one gives /2, /4, /8
	wire tick_div2 = presc_reg[0];
	wire tick_div4 = &presc_reg[1:0];
	wire tick_div8 = &presc_reg;
	// External edge reads only the settled sync stages
	wire ext_edge = edge_hit(ext_sync_reg[1], ext_sync_reg[2], ext_rising);
	wire count_tick = ~i_halt & (
		(clk_sel == frt_pkg::CLK_DIV2) ? tick_div2 :
		(clk_sel == frt_pkg::CLK_DIV4) ? tick_div4 :
		(clk_sel == frt_pkg::CLK_DIV8) ? tick_div8 :
		ext_edge);
	wire wrap_event = count_tick & (count_reg == frt_pkg::COUNT_TOP) & ~wr_low;

	// Counter next value; software reload takes priority over counting
	always_comb begin
		if (wr_low) begin
			count_next = frt_pkg::COUNT_RELOAD;
		end else if (count_tick) begin
			count_next = count_reg + 16'h0001;
		end else begin
			count_next = count_reg;
		end
	end

	// Capture edge detect; pins are never gated by output use
	wire cap1_edge = edge_hit(pin1_sync_reg[1], pin1_sync_reg[2], cap1_rising);
	wire cap2_edge = edge_hit(pin2_sync_reg[1], pin2_sync_reg[2], cap2_rising);
	wire cap1_take = cap1_edge & ~cap1_block_reg & ~wave_mode;
	wire cap2_take = cap2_edge & ~cap2_block_reg;

	// Low byte answer: buffered during a sequence, live otherwise
	wire [7:0] low_view = buf_armed_reg ? low_buf_reg : count_reg[7:0];
	wire [7:0] flags_view = {cap1_flag_reg, 1'b0, wrap_flag_reg, cap2_flag_reg, 4'h0};
	wire [7:0] rd_byte =
		(hit_cnt_hi | hit_sh_hi) ? count_reg[15:8] :
		(hit_cnt_lo | hit_sh_lo) ? low_view :
		hit_c1_hi ? cap1_reg[15:8] :
		hit_c1_lo ? cap1_reg[7:0] :
		hit_c2_hi ? cap2_reg[15:8] :
		hit_c2_lo ? cap2_reg[7:0] :
		hit_flags ? flags_view :
		hit_cr1 ? ctrl_one_reg :
		hit_cr2 ? ctrl_two_reg :
		8'h00;

	// Interrupt request stays pending while mask or enable hold it off
	wire irq_next = ~i_cpu_irq_mask & ((wrap_flag_reg & wrap_irq_enable) |
		((cap1_flag_reg | cap2_flag_reg) & capture_irq_enable));

	// Bus slave: one wait-free answer, ack falls after one cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= take;
		end
	end

	// Read data stands with ack only; unmapped reads and writes give zero
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			rd_data_reg <= 32'h0000_0000;
		end else begin
			rd_data_reg <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Control one, written from the low byte lane only
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ctrl_one_reg <= frt_pkg::CTRL_RESET;
		end else if (wr & hit_cr1) begin
			ctrl_one_reg <= i_wb_dat[7:0];
		end
	end

	// Control two; a clock select change acts from the next tick
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ctrl_two_reg <= frt_pkg::CTRL_RESET;
		end else if (wr & hit_cr2) begin
			ctrl_two_reg <= i_wb_dat[7:0];
		end
	end

	// External count pin: two sync flops plus one history stage
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			ext_sync_reg <= 3'h0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], i_ext_count_input};
		end
	end

	// Capture pin one; only the settled stages feed the edge test
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			pin1_sync_reg <= 3'h0;
		end else begin
			pin1_sync_reg <= {pin1_sync_reg[1:0], i_capture_pin_one};
		end
	end

	// Capture pin two, same chain
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			pin2_sync_reg <= 3'h0;
		end else begin
			pin2_sync_reg <= {pin2_sync_reg[1:0], i_capture_pin_two};
		end
	end

	// Prescaler freezes in halt so counting resumes in place
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			presc_reg <= frt_pkg::PRESC_RESET;
		end else if (!i_halt) begin
			presc_reg <= presc_reg + 3'h1;
		end
	end

	// Counter register; its reset value is the reload value
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			count_reg <= frt_pkg::COUNT_RELOAD;
		end else begin
			count_reg <= count_next;
		end
	end

	// Low byte snapshot; repeated high reads keep the first one
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			low_buf_reg <= 8'h00;
		end else if (rd_high && !buf_armed_reg) begin
			low_buf_reg <= count_reg[7:0];
		end
	end

	// Sequence open from a high read until the next low read
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			buf_armed_reg <= 1'b0;
		end else if (rd_high) begin
			buf_armed_reg <= 1'b1;
		end else if (rd_low) begin
			buf_armed_reg <= 1'b0;
		end
	end

	// Wrap flag: a fresh wrap wins over a clear in the same cycle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			wrap_flag_reg <= 1'b0;
		end else if (wrap_event) begin
			wrap_flag_reg <= 1'b1;
		end else if (wrap_clr_arm_reg && cnt_lo_access) begin
			wrap_flag_reg <= 1'b0;
		end
	end

	// First clear step; shadow low accesses never reach it
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			wrap_clr_arm_reg <= 1'b0;
		end else if (flags_read && wrap_flag_reg) begin
			wrap_clr_arm_reg <= 1'b1;
		end else if (cnt_lo_access) begin
			wrap_clr_arm_reg <= 1'b0;
		end
	end

	// Capture one value; a blocked channel keeps its last capture
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap1_reg <= frt_pkg::CAP_RESET;
		end else if (cap1_take) begin
			cap1_reg <= count_reg;
		end
	end

	// Capture one flag; a new capture wins over a clear
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap1_flag_reg <= 1'b0;
		end else if (cap1_take) begin
			cap1_flag_reg <= 1'b1;
		end else if (cap1_clr_arm_reg && c1_lo_access) begin
			cap1_flag_reg <= 1'b0;
		end
	end

	// Capture one clear step, armed by a flags read
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap1_clr_arm_reg <= 1'b0;
		end else if (flags_read && cap1_flag_reg) begin
			cap1_clr_arm_reg <= 1'b1;
		end else if (c1_lo_access) begin
			cap1_clr_arm_reg <= 1'b0;
		end
	end

	// High read blocks channel one so the byte pair is not torn
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap1_block_reg <= 1'b0;
		end else if (rd & hit_c1_hi) begin
			cap1_block_reg <= 1'b1;
		end else if (rd & hit_c1_lo) begin
			cap1_block_reg <= 1'b0;
		end
	end

	// Capture two value; this channel runs in every mode
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap2_reg <= frt_pkg::CAP_RESET;
		end else if (cap2_take) begin
			cap2_reg <= count_reg;
		end
	end

	// Capture two flag; a new capture wins over a clear
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap2_flag_reg <= 1'b0;
		end else if (cap2_take) begin
			cap2_flag_reg <= 1'b1;
		end else if (cap2_clr_arm_reg && c2_lo_access) begin
			cap2_flag_reg <= 1'b0;
		end
	end

	// Capture two clear step, armed by a flags read
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap2_clr_arm_reg <= 1'b0;
		end else if (flags_read && cap2_flag_reg) begin
			cap2_clr_arm_reg <= 1'b1;
		end else if (c2_lo_access) begin
			cap2_clr_arm_reg <= 1'b0;
		end
	end

	// High read blocks channel two until its low byte is read
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cap2_block_reg <= 1'b0;
		end else if (rd & hit_c2_hi) begin
			cap2_block_reg <= 1'b1;
		end else if (rd & hit_c2_lo) begin
			cap2_block_reg <= 1'b0;
		end
	end

	// Registered interrupt so the output comes from a flop
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rd_data_reg;
	assign o_irq = irq_reg;

endmodule

/* dv/free_running_timer_capture_asserts.sv */
`timescale 1ns/1ns
// Watches the bus answer and the interrupt line at the top ports
module frt_asserts (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [5:0] i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic i_cpu_irq_mask,
	input wire logic o_irq
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	a_ack_after_take: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack late");
	a_ack_needs_req: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb && !o_wb_ack))
		else $error("ack without request");
	a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack too long");
	a_dat_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
		else $error("upper data set");
	a_write_dat_zero: assert property (o_wb_ack && i_wb_we |-> o_wb_dat == 32'h0)
		else $error("data on write");
	a_idle_dat_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("data while idle");
	a_unmapped_zero: assert property (o_wb_ack && i_wb_adr > 6'h28 |-> o_wb_dat == 32'h0)
		else $error("unmapped data");
	a_flags_spare_zero: assert property (o_wb_ack && i_wb_adr == 6'h20 |->
		o_wb_dat[3:0] == 4'h0 && !o_wb_dat[6]) else $error("spare flag bits");
	a_irq_masked: assert property (i_cpu_irq_mask |=> !o_irq)
		else $error("irq while masked");
endmodule
bind free_running_timer_capture frt_asserts u_frt_asserts (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cpu_irq_mask(i_cpu_irq_mask), .o_irq(o_irq));

/* dv/frt_pins_model.sv */
`timescale 1ns/1ns
// Count and capture sources, moved just after a clock edge
module frt_pins_model (
	input wire logic i_mclk,
	output logic o_ext_count_input,
	output logic o_capture_pin_one,
	output logic o_capture_pin_two
);
	// Pins rest low until a test moves them
	initial begin
		o_ext_count_input = 1'b0;
		o_capture_pin_one = 1'b0;
		o_capture_pin_two = 1'b0;
	end
	// Gap keeps active edges well under a quarter of the clock rate
	task ext_toggle(input int n);
		repeat (n) begin
			@(posedge i_mclk);
			o_ext_count_input <= ~o_ext_count_input;
			repeat (5) @(posedge i_mclk);
		end
	endtask
	// Waits out the sync delay so the flag has landed on return
	task cap_toggle(input int ch);
		@(posedge i_mclk);
		if (ch == 1) begin
			o_capture_pin_one <= ~o_capture_pin_one;
		end else begin
			o_capture_pin_two <= ~o_capture_pin_two;
		end
		repeat (6) @(posedge i_mclk);
	endtask
endmodule

/* dv/free_running_timer_capture_bench.sv */
`timescale 1ns/1ns
module free_running_timer_capture_bench;
	logic mclk, rst_b, cyc, stb, we, ack, mask, halt, irq, ext, pin1, pin2;
	logic [5:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0] sel;
	logic [7:0] rd;
	int num_errors, n_tests, i;
	// Rows: write, address, write data, expected read data
	logic [22:0] rows [0:10] = '{{1'b0, 6'h24, 16'h0}, {1'b0, 6'h28, 16'h0},
		{1'b0, 6'h10, 16'h0}, {1'b0, 6'h14, 16'h0}, {1'b0, 6'h18, 16'h0}, {1'b0, 6'h1c, 16'h0},
		{1'b0, 6'h2c, 16'h0}, {1'b1, 6'h2c, 16'hff00}, {1'b1, 6'h24, 16'ha200},
		{1'b0, 6'h24, 16'h00a2}, {1'b1, 6'h24, 16'h0}};
	free_running_timer_capture u_free_running_timer_capture (.i_mclk(mclk), .i_rst_b(rst_b),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
		.i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_cpu_irq_mask(mask), .i_halt(halt),
		.i_ext_count_input(ext), .i_capture_pin_one(pin1), .i_capture_pin_two(pin2), .o_irq(irq));
	frt_pins_model u_frt_pins_model (.i_mclk(mclk), .o_ext_count_input(ext),
		.o_capture_pin_one(pin1), .o_capture_pin_two(pin2));
	// One classic cycle; only the watchdog ends a wait for ack
	task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {d, d, d, d};
		@(posedge mclk);
		while (ack !== 1'b1) begin
			@(posedge mclk);
		end
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task rdc(input logic [5:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#100000;
		num_errors++;
		results;
	end
	initial begin
		{rst_b, cyc, stb, we, mask, halt, adr, wdat, sel} = {44'h0, 4'hf};
		num_errors = 0;
		n_tests = 0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		for (i = 0; i < 11; i++) begin
			wb(rows[i][22], rows[i][21:16], rows[i][15:8]);
			chk(rd, rows[i][7:0]);
		end
		// Low lane disabled: the write must leave control one alone
		sel <= 4'he;
		wb(1'b1, 6'h24, 8'hff);
		sel <= 4'hf;
		rdc(6'h24, 8'h00);
		$display("register table done");
		// Halt freezes the count so byte values are exact
		halt <= 1'b1;
		wb(1'b1, 6'h04, 8'h55);
		rdc(6'h00, 8'hff);
		halt <= 1'b0;
		repeat (4) @(posedge mclk);
		halt <= 1'b1;
		rdc(6'h08, 8'hff);
		rdc(6'h0c, 8'hfc);
		rdc(6'h04, 8'hfe);
		halt <= 1'b0;
		repeat (12) @(posedge mclk);
		halt <= 1'b1;
		rdc(6'h20, 8'h20);
		wb(1'b1, 6'h24, 8'h20);
		chk({7'h0, irq}, 8'h01);
		mask <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({7'h0, irq}, 8'h00);
		mask <= 1'b0;
		rdc(6'h0c, 8'h04);
		rdc(6'h20, 8'h20);
		rdc(6'h04, 8'h04);
		rdc(6'h20, 8'h00);
		chk({7'h0, irq}, 8'h00);
		$display("counter and wrap done");
		// External count, rising then falling edges
		wb(1'b1, 6'h28, 8'h0d);
		halt <= 1'b0;
		wb(1'b1, 6'h04, 8'h00);
		u_frt_pins_model.ext_toggle(6);
		rdc(6'h00, 8'hff);
		rdc(6'h04, 8'hff);
		wb(1'b1, 6'h28, 8'h0c);
		u_frt_pins_model.ext_toggle(4);
		rdc(6'h00, 8'h00);
		rdc(6'h04, 8'h01);
		$display("external count done");
		// Count now sits at 0001 with the wrap flag set
		wb(1'b1, 6'h24, 8'h82);
		wb(1'b1, 6'h28, 8'h0e);
		u_frt_pins_model.cap_toggle(1);
		chk({7'h0, irq}, 8'h01);
		rdc(6'h20, 8'ha0);
		rdc(6'h10, 8'h00);
		rdc(6'h14, 8'h01);
		rdc(6'h20, 8'h20);
		rdc(6'h18, 8'h00);
		u_frt_pins_model.cap_toggle(2);
		rdc(6'h20, 8'h20);
		rdc(6'h1c, 8'h00);
		u_frt_pins_model.cap_toggle(2);
		rdc(6'h20, 8'h20);
		u_frt_pins_model.cap_toggle(2);
		rdc(6'h20, 8'h30);
		wb(1'b1, 6'h28, 8'h2e);
		u_frt_pins_model.cap_toggle(1);
		u_frt_pins_model.cap_toggle(1);
		rdc(6'h20, 8'h30);
		$display("capture done");
		// Mid-run reset with pins left high: no false capture may follow
		halt <= 1'b1;
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		chk({7'h0, irq}, 8'h00);
		rdc(6'h00, 8'hff);
		rdc(6'h04, 8'hfc);
		rdc(6'h20, 8'h00);
		rdc(6'h1c, 8'h00);
		$display("mid-run reset done");
		results;
	end
endmodule
